// ==== hdl/modbus_slave_error_monitor.sv ====
`timescale 1ns/100ps
// Overview of operation
// RQ1: Keep the latest communication error code readable.
// RQ2: Count received frames; a control field selects which frame class counts.
// RQ3: Count every normal received frame, any address.
// RQ4: Count normal received frames addressed to this slave only.
// RQ5: Count every abnormal received frame, any address.
// RQ6: Abnormal means CRC mismatch or 1.5-character gap loss; else normal.
// RQ7: Count each response frame sent.
// RQ8: Count received bytes and transmitted bytes separately.
// RQ9: Count register writes whose data is rejected.
// RQ10: Keep the ten newest error codes, newest first, cleared at power-up.
// RQ11: Status indicator goes red only for code 84h.
// RQ12: Unsupported function or diagnostic sub-function not 00h gives 88h, exception 01h.
// RQ13: Start register beyond 57FFh or start+count reaching 5800h gives 88h, exception 02h.
// RQ14: Tool download or initialisation gives 89h, exception 04h.
// RQ15: Busy flag or memory alarm gives 8Ah, exception 04h.
// RQ16: Zero count, bad byte count or bad length gives 8Ch, exception 03h.
// RQ17: Written value out of range gives 8Ch, exception 04h.
// RQ18: Command that cannot execute gives 8Dh, exception 04h.
// RQ19: Slave response mode 0 answers slave errors normally.
// RQ20: Transmission errors drop the query, no response, recorded as 84h.
// RQ21: Consecutive transmission errors reaching limit raise alarm 84h; good exchange resets.
// RQ22: No good exchange within timeout raises alarm 85h.
// RQ23: Each monitored value is 32 bits, read as two 16-bit halves.
// RQ24: Counters wrap past maximum and clear at power-up.
module modbus_slave_error_monitor
  import comm_mon_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link events from the frame parser
  input wire logic RX_BYTE,
  input wire logic TX_BYTE,
  input wire logic TX_FRAME,
  input wire logic RX_FRAME_END,
  input wire logic RX_OWN_ADDR,
  input wire logic RX_CRC_BAD,
  input wire logic RX_GAP_LOSS,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_PARITY_ERR,
  input wire logic [8:0] RX_MSG_LEN,
  // decoded query fields
  input wire logic [7:0] Q_FUNC,
  input wire logic Q_FUNC_OK,
  input wire logic [7:0] Q_SUBFN,
  input wire logic [15:0] Q_START,
  input wire logic [15:0] Q_COUNT,
  input wire logic [7:0] Q_BYTES,
  input wire logic Q_LEN_BAD,
  input wire logic Q_IS_WRITE,
  input wire logic Q_VALUE_BAD,
  input wire logic Q_EXEC_BAD,
  // device conditions, asynchronous
  input wire logic TOOL_ACTIVE,
  input wire logic INTERNAL_BUSY_FLAG,
  input wire logic NVM_ALARM,
  // verdict to the responder
  output logic VERDICT_VALID,
  output logic RESP_DISCARD,
  output logic RESP_EXCEPTION,
  output logic [7:0] RESP_EXC_CODE,
  // indicators and alarms
  output logic COMM_STATUS_INDICATOR,
  output logic ALARM_ACTIVE,
  output logic [7:0] ALARM_CODE
);
  // ************************************
  // pin synchronisers
  // ************************************
  logic [2:0] sy_tool;
  logic [2:0] sy_busy;
  logic [2:0] sy_nvm;
  logic tool_q;
  logic busy_q;
  logic nvm_q;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      sy_tool <= 3'h0;
      sy_busy <= 3'h0;
      sy_nvm <= 3'h0;
      tool_q <= 1'b0;
      busy_q <= 1'b0;
      nvm_q <= 1'b0;
    end
    else
    begin
      sy_tool <= {sy_tool[1:0], TOOL_ACTIVE};
      sy_busy <= {sy_busy[1:0], INTERNAL_BUSY_FLAG};
      sy_nvm <= {sy_nvm[1:0], NVM_ALARM};
      // a change counts once stages two and three agree
      if (sy_tool[1] == sy_tool[2]) tool_q <= sy_tool[2];
      if (sy_busy[1] == sy_busy[2]) busy_q <= sy_busy[2];
      if (sy_nvm[1] == sy_nvm[2]) nvm_q <= sy_nvm[2];
    end
  end

  // ************************************
  // apb registers
  // ************************************
  logic [31:0] ctrl;
  logic [15:0] err_limit;
  logic [31:0] timeout_ms;
  logic [31:0] next_ctrl;
  logic [15:0] next_err_limit;
  logic [31:0] next_timeout_ms;
  logic wr_en;
  logic rd_en;
  logic alm_clr;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign alm_clr = wr_en && (PADDR == ADDR_CTRL) && PWDATA[CTRL_ALM_CLR];

  always_comb
  begin
    next_ctrl = ctrl;
    next_err_limit = err_limit;
    next_timeout_ms = timeout_ms;
    if (wr_en && PADDR == ADDR_CTRL)
    begin
      next_ctrl = PWDATA & 32'h0000_0007;
    end
    else if (wr_en && PADDR == ADDR_ERR_LIMIT)
    begin
      next_err_limit = PWDATA[15:0];
    end
    else if (wr_en && PADDR == ADDR_TIMEOUT)
    begin
      next_timeout_ms = PWDATA;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      ctrl <= CTRL_RESET;
      err_limit <= ERR_LIMIT_RESET;
      timeout_ms <= TIMEOUT_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
      err_limit <= next_err_limit;
      timeout_ms <= next_timeout_ms;
    end
  end

  rx_sel_t rx_sel;
  assign rx_sel = rx_sel_t'(ctrl[CTRL_RX_SEL_LSB +: 2]);

  // ************************************
  // frame classification
  // ************************************
  logic trans_err;
  logic rx_good;
  logic rx_bad;
  logic [NUM_CNT-1:0] cnt_inc;
  logic [31:0] cnt [NUM_CNT];
  logic rx_sel_hit;
  // RQ20 transmission errors
  assign trans_err = RX_FRAMING_ERR || RX_PARITY_ERR || RX_CRC_BAD || (int'(RX_MSG_LEN) > MAX_MSG_BYTES);
  // RQ6 normal versus abnormal
  assign rx_bad = RX_FRAME_END && (RX_CRC_BAD || RX_GAP_LOSS);
  assign rx_good = RX_FRAME_END && !(RX_CRC_BAD || RX_GAP_LOSS);

  // RQ2 selectable receive count
  always_comb
  begin
    case (rx_sel)
      RXSEL_OWN: rx_sel_hit = rx_good && RX_OWN_ADDR;
      RXSEL_BAD: rx_sel_hit = rx_bad;
      default: rx_sel_hit = RX_FRAME_END;
    endcase
  end

  // RQ3 RQ4 RQ5 frame class counters
  // RQ7 RQ8 link traffic counters
  assign cnt_inc[0] = rx_sel_hit;
  assign cnt_inc[1] = rx_good;
  assign cnt_inc[2] = rx_good && RX_OWN_ADDR;
  assign cnt_inc[3] = rx_bad;
  assign cnt_inc[4] = TX_FRAME;
  assign cnt_inc[5] = RX_BYTE;
  assign cnt_inc[6] = TX_BYTE;

  // ************************************
  // command checks
  // ************************************
  chk_state_t state;
  chk_state_t next_state;
  logic [7:0] err_code;
  logic [7:0] exc_code;
  logic [7:0] next_err_code;
  logic [7:0] next_exc_code;
  logic slave_err;
  logic next_slave_err;
  // write flag kept with the frame, the query fields do not stand past it
  logic q_wr;
  logic [16:0] reg_end;
  assign reg_end = {1'b0, Q_START} + {1'b0, Q_COUNT};

  always_comb
  begin
    next_err_code = ERR_NONE;
    next_exc_code = 8'h00;
    next_slave_err = 1'b0;
    // RQ20 discard on transmission error
    if (trans_err)
    begin
      next_err_code = ERR_TRANS;
    end
    // RQ12 undefined function
    else if (!Q_FUNC_OK || (Q_FUNC == FC_DIAG && Q_SUBFN != SUBFN_ECHO))
    begin
      next_err_code = ERR_UNDEF;
      next_exc_code = EXC_FUNC;
    end
    // RQ13 address window
    else if (Q_START > REG_LAST || reg_end >= REG_END)
    begin
      next_err_code = ERR_UNDEF;
      next_exc_code = EXC_ADDR;
    end
    // RQ16 malformed data
    else if (Q_COUNT == 16'h0000 || (Q_IS_WRITE && {8'h00, Q_BYTES} != {Q_COUNT[14:0], 1'b0}) || Q_LEN_BAD)
    begin
      next_err_code = ERR_RANGE;
      next_exc_code = EXC_DATA;
    end
    // RQ14 tool session
    else if (tool_q)
    begin
      next_err_code = ERR_TOOL;
      next_exc_code = EXC_DEV;
      next_slave_err = 1'b1;
    end
    // RQ15 memory busy
    else if (busy_q || nvm_q)
    begin
      next_err_code = ERR_NVM;
      next_exc_code = EXC_DEV;
      next_slave_err = 1'b1;
    end
    // RQ17 value out of range
    else if (Q_VALUE_BAD)
    begin
      next_err_code = ERR_RANGE;
      next_exc_code = EXC_DEV;
      next_slave_err = 1'b1;
    end
    // RQ18 execution refused
    else if (Q_EXEC_BAD)
    begin
      next_err_code = ERR_EXEC;
      next_exc_code = EXC_DEV;
      next_slave_err = 1'b1;
    end
  end

  always_comb
  begin
    case (state)
      ST_IDLE: next_state = RX_FRAME_END ? ST_CHECK : ST_IDLE;
      ST_CHECK: next_state = ST_REPORT;
      default: next_state = ST_IDLE;
    endcase
  end

  logic latch;
  assign latch = RX_FRAME_END && state == ST_IDLE;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      state <= ST_IDLE;
      err_code <= ERR_NONE;
      exc_code <= 8'h00;
      slave_err <= 1'b0;
      q_wr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (latch)
      begin
        err_code <= next_err_code;
        exc_code <= next_exc_code;
        slave_err <= next_slave_err;
        q_wr <= Q_IS_WRITE;
      end
    end
  end

  // ************************************
  // verdict and statistics
  // ************************************
  logic is_err;
  logic is_trans;
  logic proper;
  logic report;
  assign report = state == ST_CHECK;
  assign is_err = err_code != ERR_NONE;
  assign is_trans = err_code == ERR_TRANS;
  assign proper = report && !is_err;
  assign VERDICT_VALID = report;
  assign RESP_DISCARD = report && is_trans;
  // RQ19 slave errors may answer normally
  assign RESP_EXCEPTION = report && is_err && !is_trans && !(slave_err && !ctrl[CTRL_SLV_RESP]);
  assign RESP_EXC_CODE = exc_code;
  // RQ9 rejected writes
  assign cnt_inc[7] = report && q_wr && is_err && !is_trans;

  // RQ24 wrapping counters
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++)
    begin : g_cnt
      stat_counter #(.WIDTH(32)) u_cnt (
        .clk(SYS_CLK),
        .reset_n(RESET_N),
        .inc(cnt_inc[g]),
        .count(cnt[g])
      );
    end
  endgenerate

  // RQ10 ten-deep history
  logic [7:0] hist_data;
  err_history #(.DEPTH(HIST_DEPTH)) u_hist (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .push(report && is_err),
    .code(err_code),
    .rd_idx(PADDR[5:2]),
    .rd_data(hist_data)
  );

  // ************************************
  // alarms and indicator
  // ************************************
  logic [15:0] consec;
  logic [15:0] next_consec;
  logic [31:0] ms_cnt;
  logic [31:0] next_ms_cnt;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic [1:0] alarm;
  logic [1:0] next_alarm;
  logic [7:0] last_err;
  logic [7:0] next_last_err;
  logic ind;
  logic next_ind;

  always_comb
  begin
    next_consec = consec;
    next_tick = (int'(tick) == TICK_CYC - 1) ? 16'h0000 : tick + 16'h0001;
    next_ms_cnt = ms_cnt;
    next_alarm = alarm;
    next_last_err = last_err;
    next_ind = ind;
    if (alm_clr)
    begin
      next_alarm = 2'b00;
    end
    // RQ21 consecutive transmission errors
    if (report && is_trans)
    begin
      next_consec = consec + 16'h0001;
      if (err_limit != 16'h0000 && next_consec >= err_limit) next_alarm[0] = 1'b1;
    end
    else if (proper)
    begin
      next_consec = 16'h0000;
    end
    // RQ22 timeout restarted by a proper exchange
    if (proper)
    begin
      next_ms_cnt = 32'h0;
      next_tick = 16'h0000;
    end
    else if (timeout_ms != 32'h0 && int'(tick) == TICK_CYC - 1 && ms_cnt != timeout_ms)
    begin
      next_ms_cnt = ms_cnt + 32'h1;
      if (ms_cnt + 32'h1 == timeout_ms) next_alarm[1] = 1'b1;
    end
    // RQ1 latest error code
    // RQ11 indicator red only on 84h
    if (report && is_err)
    begin
      next_last_err = err_code;
      next_ind = is_trans;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      consec <= 16'h0000;
      tick <= 16'h0000;
      ms_cnt <= 32'h0;
      alarm <= 2'b00;
      last_err <= ERR_NONE;
      ind <= 1'b0;
    end
    else
    begin
      consec <= next_consec;
      tick <= next_tick;
      ms_cnt <= next_ms_cnt;
      alarm <= next_alarm;
      last_err <= next_last_err;
      ind <= next_ind;
    end
  end
  assign COMM_STATUS_INDICATOR = ind;
  assign ALARM_ACTIVE = |alarm;
  assign ALARM_CODE = alarm[0] ? ERR_TRANS : (alarm[1] ? ALM_TIMEOUT : ERR_NONE);

  // ************************************
  // apb read mux
  // ************************************
  // RQ23 each value a 32-bit word, two modbus halves
  logic [31:0] next_prdata;
  logic next_pslverr;
  always_comb
  begin
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    if (PADDR == ADDR_CTRL) next_prdata = ctrl;
    else if (PADDR == ADDR_ERR_LIMIT) next_prdata = {16'h0000, err_limit};
    else if (PADDR == ADDR_TIMEOUT) next_prdata = timeout_ms;
    else if (PADDR == ADDR_LAST_ERR) next_prdata = {24'h0, last_err};
    else if (PADDR == ADDR_STATUS) next_prdata = {16'h0, ALARM_CODE, 6'h0, ind, ALARM_ACTIVE};
    else if (PADDR >= ADDR_CNT_BASE && PADDR < ADDR_HIST_BASE && PADDR[1:0] == 2'b00) next_prdata = cnt[PADDR[4:2]];
    else if (PADDR >= ADDR_HIST_BASE && int'(PADDR[5:2]) < HIST_DEPTH && PADDR[7:6] == 2'b01) next_prdata = 32'h0;
    else next_pslverr = 1'b1;
  end

  logic hist_sel;
  logic [31:0] rd_reg;
  logic err_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      rd_reg <= 32'h0;
      err_reg <= 1'b0;
      hist_sel <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      rd_reg <= next_prdata;
      err_reg <= next_pslverr;
      hist_sel <= rd_en && PADDR[7:6] == 2'b01 && int'(PADDR[5:2]) < HIST_DEPTH;
    end
  end
  assign PRDATA = hist_sel ? {24'h0, hist_data} : rd_reg;
  assign PSLVERR = PSEL && PENABLE && err_reg;

  // ************************************
  // checks
  // ************************************
  property p_discard;
    @(posedge SYS_CLK) disable iff (!RESET_N) RX_FRAME_END && trans_err && state == ST_IDLE |=> RESP_DISCARD && !RESP_EXCEPTION;
  endproperty
  a_discard: assert property (p_discard) else $error("transmission error not discarded"); // RQ20
  property p_undef;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      RX_FRAME_END && state == ST_IDLE && !trans_err && !Q_FUNC_OK |=> RESP_EXC_CODE == EXC_FUNC && !RESP_DISCARD;
  endproperty
  a_undef: assert property (p_undef) else $error("bad function not reported"); // RQ12
  property p_ind;
    @(posedge SYS_CLK) disable iff (!RESET_N) report && is_err |=> COMM_STATUS_INDICATOR == (last_err == ERR_TRANS);
  endproperty
  a_ind: assert property (p_ind) else $error("indicator wrong"); // RQ11
  property p_good;
    @(posedge SYS_CLK) disable iff (!RESET_N) rx_good |=> cnt[1] == $past(cnt[1]) + 32'h1;
  endproperty
  a_good: assert property (p_good) else $error("normal counter missed"); // RQ3
  property p_bad;
    @(posedge SYS_CLK) disable iff (!RESET_N) RX_FRAME_END && RX_GAP_LOSS |=> cnt[3] == $past(cnt[3]) + 32'h1;
  endproperty
  a_bad: assert property (p_bad) else $error("abnormal counter missed"); // RQ5
  property p_own;
    @(posedge SYS_CLK) disable iff (!RESET_N) !(rx_good && RX_OWN_ADDR) |=> cnt[2] == $past(cnt[2]);
  endproperty
  a_own: assert property (p_own) else $error("own counter moved"); // RQ4
  property p_reset_consec;
    @(posedge SYS_CLK) disable iff (!RESET_N) proper |=> consec == 16'h0000 && ms_cnt == 32'h0;
  endproperty
  a_reset_consec: assert property (p_reset_consec) else $error("proper exchange did not reset"); // RQ21
  property p_txb;
    @(posedge SYS_CLK) disable iff (!RESET_N) TX_BYTE |=> cnt[6] != $past(cnt[6]);
  endproperty
  a_txb: assert property (p_txb) else $error("tx byte not counted"); // RQ8
  c_trans: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) RESP_DISCARD);
  c_alarm: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) alarm[0]);
  c_exc: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) RESP_EXCEPTION);
endmodule

// ==== hdl/comm_mon_pkg.sv ====
package comm_mon_pkg;
  // ************************************
  // register map (byte addresses)
  // ************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ERR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
  localparam logic [7:0] ADDR_LAST_ERR = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h20;
  localparam logic [7:0] ADDR_HIST_BASE = 8'h40;
  localparam int NUM_CNT = 8;
  localparam int HIST_DEPTH = 10;
  // ************************************
  // control fields and reset values
  // ************************************
  localparam int CTRL_RX_SEL_LSB = 0;
  localparam int CTRL_SLV_RESP = 2;
  localparam int CTRL_ALM_CLR = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [15:0] ERR_LIMIT_RESET = 16'h0003;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_0000;
  // ************************************
  // error and exception codes
  // ************************************
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_TRANS = 8'h84;
  localparam logic [7:0] ALM_TIMEOUT = 8'h85;
  localparam logic [7:0] ERR_UNDEF = 8'h88;
  localparam logic [7:0] ERR_TOOL = 8'h89;
  localparam logic [7:0] ERR_NVM = 8'h8a;
  localparam logic [7:0] ERR_RANGE = 8'h8c;
  localparam logic [7:0] ERR_EXEC = 8'h8d;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_DEV = 8'h04;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] SUBFN_ECHO = 8'h00;
  localparam logic [15:0] REG_LAST = 16'h57ff;
  localparam logic [16:0] REG_END = 17'h05800;
  localparam int MAX_MSG_BYTES = 256;
  // timeout unit 1 ms at 40 MHz
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // receive counter select
  typedef enum logic [1:0] {RXSEL_ALL = 2'b00, RXSEL_OWN = 2'b01, RXSEL_BAD = 2'b11} rx_sel_t;
  // check state: gray along idle, check, report
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CHECK = 2'b01, ST_REPORT = 2'b11} chk_state_t;
endpackage

// ==== hdl/err_history.sv ====
`timescale 1ns/100ps
module err_history
  import comm_mon_pkg::*;
#(
  parameter int DEPTH = 10
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic [7:0] code,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_mem [DEPTH];
  logic [7:0] next_rd_data;

  // ************************************
  // shift register, newest at slot 0
  // ************************************
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (push)
    begin
      next_mem[0] = code;
      for (int i = 1; i < DEPTH; i++)
      begin
        next_mem[i] = mem[i-1];
      end
    end
    next_rd_data = (int'(rd_idx) < DEPTH) ? mem[rd_idx] : 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end
    else
    begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule

// ==== hdl/stat_counter.sv ====
`timescale 1ns/100ps
module stat_counter #(
  parameter int WIDTH = 32
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inc,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] next_count;

  // wraps to zero naturally after all ones
  always_comb
  begin
    next_count = inc ? count + 1'b1 : count;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end
endmodule

// ==== dv/host_link_model.sv ====
`timescale 1ns/100ps
// ****************
// host side of the link, seen through the frame parser
// ****************
module host_link_model
(
  // clock
  input wire logic clk,
  // link events
  output logic rx_byte,
  output logic frame_end,
  output logic [4:0] flags,
  output logic [8:0] msg_len,
  // verdict seen
  input wire logic verdict_valid,
  input wire logic resp_discard,
  input wire logic resp_exception,
  output logic got,
  output logic disc,
  output logic exc
);
  initial
  begin
    rx_byte = 1'b0;
    frame_end = 1'b0;
    flags = 5'h00;
    msg_len = 9'h000;
    got = 1'b0;
    disc = 1'b0;
    exc = 1'b0;
  end
  // flags = own, crc bad, gap loss, framing, parity
  task automatic frame(input logic [4:0] f, input int nb);
    repeat (nb)
    begin
      @(posedge clk);
      rx_byte <= 1'b1;
      @(posedge clk);
      rx_byte <= 1'b0;
    end
    @(posedge clk);
    frame_end <= 1'b1;
    flags <= f;
    msg_len <= nb[8:0];
    @(posedge clk);
    frame_end <= 1'b0;
    // fields are stale after the pulse, so scramble them
    flags <= ~f;
    msg_len <= ~nb[8:0];
    #1;
    got = verdict_valid;
    disc = resp_discard;
    exc = resp_exception;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ==== dv/tb_modbus_slave_error_monitor.sv ====
`timescale 1ns/100ps
module tb_modbus_slave_error_monitor;
  import comm_mon_pkg::*;
  // ****************
  // signals
  // ****************
  logic sys_clk, reset_n, psel, penable, pwrite, tx_byte, tx_frame, pready, pslverr, err;
  logic [7:0] paddr, q_func, q_subfn, q_bytes, resp_exc_code, alarm_code;
  logic [31:0] pwdata, prdata, rdat;
  logic rx_byte, frame_end, got, disc, exc, verdict_valid, resp_discard, resp_exception, comm_ind, alarm_active;
  logic [4:0] flags;
  logic [2:0] dev;
  logic [8:0] msg_len;
  logic [15:0] q_start, q_count;
  logic q_func_ok, q_len_bad, q_is_write, q_value_bad, q_exec_bad;
  int bad_count = 0;
  int compares = 0;
  modbus_slave_error_monitor i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_BYTE(rx_byte), .TX_BYTE(tx_byte), .TX_FRAME(tx_frame), .RX_FRAME_END(frame_end),
    .RX_OWN_ADDR(flags[4]), .RX_CRC_BAD(flags[3]), .RX_GAP_LOSS(flags[2]), .RX_FRAMING_ERR(flags[1]),
    .RX_PARITY_ERR(flags[0]), .RX_MSG_LEN(msg_len), .Q_FUNC(q_func), .Q_FUNC_OK(q_func_ok),
    .Q_SUBFN(q_subfn), .Q_START(q_start), .Q_COUNT(q_count), .Q_BYTES(q_bytes), .Q_LEN_BAD(q_len_bad),
    .Q_IS_WRITE(q_is_write), .Q_VALUE_BAD(q_value_bad), .Q_EXEC_BAD(q_exec_bad), .TOOL_ACTIVE(dev[2]),
    .INTERNAL_BUSY_FLAG(dev[1]), .NVM_ALARM(dev[0]), .VERDICT_VALID(verdict_valid),
    .RESP_DISCARD(resp_discard), .RESP_EXCEPTION(resp_exception), .RESP_EXC_CODE(resp_exc_code),
    .COMM_STATUS_INDICATOR(comm_ind), .ALARM_ACTIVE(alarm_active), .ALARM_CODE(alarm_code));
  host_link_model i_host (.clk(sys_clk), .rx_byte(rx_byte), .frame_end(frame_end), .flags(flags),
    .msg_len(msg_len), .verdict_valid(verdict_valid), .resp_discard(resp_discard), .resp_exception(resp_exception),
    .got(got), .disc(disc), .exc(exc));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic tx(input int nb);
    repeat (nb)
    begin
      @(posedge sys_clk);
      tx_byte <= 1'b1;
      @(posedge sys_clk);
      tx_byte <= 1'b0;
    end
    @(posedge sys_clk);
    tx_frame <= 1'b1;
    @(posedge sys_clk);
    tx_frame <= 1'b0;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_ERR_LIMIT, {16'h0, ERR_LIMIT_RESET});
    for (int i = 0; i < NUM_CNT; i++)
      rd(ADDR_CNT_BASE + 8'(4 * i), 32'h0);
    rd(8'hfc, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_good();
    i_host.frame(5'h10, 4);
    chk({29'h0, got, disc, exc}, 32'h4);
    i_host.frame(5'h00, 3);
    rd(ADDR_CNT_BASE, 32'h2);
    rd(ADDR_CNT_BASE + 8'h04, 32'h2);
    rd(ADDR_CNT_BASE + 8'h08, 32'h1);
    rd(ADDR_CNT_BASE + 8'h14, 32'h7);
  endtask
  task automatic t_crc();
    i_host.frame(5'h18, 5);
    chk({29'h0, got, disc, exc}, 32'h6);
    rd(ADDR_CNT_BASE + 8'h0c, 32'h1);
    rd(ADDR_LAST_ERR, {24'h0, ERR_TRANS});
    rd(ADDR_STATUS, 32'h2);
    chk({31'h0, comm_ind}, 32'h1);
    rd(ADDR_HIST_BASE, {24'h0, ERR_TRANS});
  endtask
  task automatic t_func();
    q_func_ok <= 1'b0;
    i_host.frame(5'h10, 2);
    q_func_ok <= 1'b1;
    chk({24'h0, resp_exc_code}, {24'h0, EXC_FUNC});
    chk({31'h0, exc}, 32'h1);
    chk({31'h0, comm_ind}, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_HIST_BASE, {24'h0, ERR_UNDEF});
    rd(ADDR_HIST_BASE + 8'h04, {24'h0, ERR_TRANS});
  endtask
  task automatic t_addr();
    // start plus count lands exactly on the first illegal register
    q_start <= REG_LAST;
    q_is_write <= 1'b1;
    i_host.frame(5'h10, 8);
    q_start <= 16'h0;
    q_is_write <= 1'b0;
    chk({24'h0, resp_exc_code}, {24'h0, EXC_ADDR});
    rd(ADDR_LAST_ERR, {24'h0, ERR_UNDEF});
    rd(ADDR_CNT_BASE + 8'h1c, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    q_value_bad <= 1'b1;
    i_host.frame(5'h10, 2);
    q_value_bad <= 1'b0;
    chk({16'h0, resp_exc_code, 7'h0, exc}, {16'h0, EXC_DEV, 8'h0});
    rd(ADDR_LAST_ERR, {24'h0, ERR_RANGE});
  endtask
  task automatic t_tx();
    tx(3);
    tx(2);
    rd(ADDR_CNT_BASE + 8'h10, 32'h2);
    rd(ADDR_CNT_BASE + 8'h18, 32'h5);
  endtask
  task automatic t_alarm();
    i_host.frame(5'h10, 2);
    i_host.frame(5'h11, 2);
    i_host.frame(5'h12, 2);
    rd(ADDR_STATUS, 32'h2);
    i_host.frame(5'h11, 2);
    rd(ADDR_STATUS, {16'h0, ERR_TRANS, 8'h03});
    chk({23'h0, alarm_active, alarm_code}, {23'h0, 1'b1, ERR_TRANS});
    apb(1'b1, ADDR_CTRL, CTRL_RESET | 32'h8);
    rd(ADDR_STATUS, 32'h2);
  endtask
  task automatic t_gap();
    apb(1'b1, ADDR_CTRL, CTRL_RESET | 32'h3);
    i_host.frame(5'h14, 3);
    i_host.frame(5'h10, 2);
    rd(ADDR_CNT_BASE + 8'h0c, 32'h2);
    rd(ADDR_CNT_BASE, 32'hb);
  endtask
  task automatic t_dev();
    for (int i = 0; i < 3; i++)
    begin
      dev <= 3'(1 << i);
      repeat (6) @(posedge sys_clk);
      i_host.frame(5'h10, 2);
      dev <= 3'h0;
      chk({24'h0, resp_exc_code}, {24'h0, EXC_DEV});
      rd(ADDR_LAST_ERR, {24'h0, (i == 2) ? ERR_TOOL : ERR_NVM});
    end
  endtask
  task automatic t_timeout();
    apb(1'b1, ADDR_TIMEOUT, 32'h1);
    chk({31'h0, alarm_active}, 32'h0);
    repeat (TICK_CYC) @(posedge sys_clk);
    chk({23'h0, alarm_active, alarm_code}, {23'h0, 1'b1, ALM_TIMEOUT});
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(ADDR_CNT_BASE + 8'h14, 32'h0);
    rd(ADDR_HIST_BASE, 32'h0);
    chk({31'h0, alarm_active}, 32'h0);
  endtask
  // ****************
  // run
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, tx_byte, tx_frame, q_func_ok, q_len_bad} = 8'h02;
    {dev, q_is_write, q_value_bad, q_exec_bad, paddr, pwdata} = 46'h0;
    {q_func, q_subfn, q_start, q_count, q_bytes} = {8'h03, 8'h00, 16'h0, 16'h1, 8'h02};
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_good();
    t_crc();
    t_func();
    t_addr();
    t_tx();
    t_alarm();
    t_gap();
    t_dev();
    t_timeout();
    complete_run();
  end
endmodule
